// ### hdl/supervisor_pkg.sv
package supervisor_pkg;

  // ****************************************************************
  // clock and watchdog timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned KICK_PERIOD_MS  = 1600;
  localparam longint      KICK_CYCLES_L   = (64'(CLK_HZ) * KICK_PERIOD_MS) / 1000;
  localparam int unsigned KICK_CYCLES     = int'(KICK_CYCLES_L);
  localparam int unsigned CNT_W           = 26;

  // ****************************************************************
  // power-fail filter
  // ****************************************************************
  localparam logic [3:0]  PF_FILTER_LEN   = 4'h3;

  // ****************************************************************
  // watchdog states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    WD_OFF     = 3'b001,
    WD_RUN     = 3'b010,
    WD_EXPIRED = 3'b100
  } wd_state_t;

endpackage : supervisor_pkg

// ### hdl/power_fail_filter.sv
`timescale 1ns/10ps

// ****************************************************************
// power-fail warning: comparator level debounced to an active-low flag
// ****************************************************************
module power_fail_filter
  import supervisor_pkg::*;
(
  input  wire logic clk,                       // system clock
  input  wire logic srst,                      // synchronous reset, active high
  input  wire logic below_threshold,           // comparator: sense input under threshold
  output logic      power_fail_warning_output_n // low while supply is failing
);

  typedef struct packed
  {
    logic [3:0] count;
    logic       warn_n;
  } pf_state_t;

  pf_state_t cur;
  pf_state_t next_cur;

  // a short run of agreeing samples rejects comparator chatter near the threshold
  always_comb
  begin
    next_cur = cur;
    if (below_threshold == !cur.warn_n)
      next_cur.count = 4'h0;
    else if (cur.count == PF_FILTER_LEN)
    begin
      next_cur.warn_n = !below_threshold;
      next_cur.count  = 4'h0;
    end
    else
      next_cur.count = cur.count + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cur <= '{count: 4'h0, warn_n: 1'b1};
    else
      cur <= next_cur;
  end

  assign power_fail_warning_output_n = cur.warn_n;

  pf_assert_a: assert property (@(posedge clk) disable iff (srst)
    below_threshold [*5] |=> !power_fail_warning_output_n)
    else $error("power-fail warning not asserted after sustained low sense");

  pf_release_a: assert property (@(posedge clk) disable iff (srst)
    !below_threshold [*5] |=> power_fail_warning_output_n)
    else $error("power-fail warning not released after sense recovered");

  pf_warn_c: cover property (@(posedge clk) disable iff (srst)
    $fell(power_fail_warning_output_n));

endmodule : power_fail_filter

// ### hdl/supervisor_watchdog.sv
`timescale 1ns/10ps

// How it works
// - watchdog runs only while the enable jumper is fitted; else never resets.
// - no kick within the timeout drives the timeout output low, asserting reset.
// - after a timeout the output stays low until the next kick transition or jumper removal.
// - sense input below threshold asserts the active-low power-fail warning.
module supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = KICK_CYCLES
)
(
  input  wire logic clk,                         // 25 MHz system clock
  input  wire logic srst,                        // synchronous reset, active high
  input  wire logic watchdog_kick_input,         // toggled by host software
  input  wire logic watchdog_enable_jumper,      // high when jumper fitted
  input  wire logic power_fail_sense_input,      // comparator: high when below threshold
  output logic      watchdog_timeout_output_n,   // low drives system reset
  output logic      power_fail_warning_output_n  // low drives the host nmi
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    wd_state_t        state;
    logic             kick_prev;
    logic             kick_seen;
    logic [CNT_W-1:0] count;
    logic             timeout_n;
  } wd_regs_t;

  wd_regs_t cur;
  wd_regs_t next_cur;
  logic     kick_edge;

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYCLES - 1);

  // true on the last cycle of the interval
  function automatic logic at_limit(input logic [CNT_W-1:0] c);
    return c == LIMIT;
  endfunction : at_limit

  // the first sample after reset only primes kick_prev, so reset never looks like a kick
  // the pin level itself is meaningless: software may park it high or low
  assign kick_edge = cur.kick_seen && (watchdog_kick_input != cur.kick_prev);

  // ****************************************************************
  // watchdog sequencing
  // ****************************************************************
  always_comb
  begin
    next_cur           = cur;
    next_cur.kick_prev = watchdog_kick_input;
    next_cur.kick_seen = 1'b1;
    case (cur.state)
      WD_OFF:
      begin
        next_cur.count     = '0;
        next_cur.timeout_n = 1'b1;
        if (watchdog_enable_jumper)
          next_cur.state = WD_RUN;
      end
      WD_RUN:
      begin
        if (!watchdog_enable_jumper)
          next_cur.state = WD_OFF;
        else if (kick_edge)
          next_cur.count = '0;
        else if (at_limit(cur.count))
        begin
          next_cur.state     = WD_EXPIRED;
          next_cur.timeout_n = 1'b0;
        end
        else
          next_cur.count = cur.count + CNT_W'(1);
      end
      WD_EXPIRED:
      begin
        // held low across the host reset; only a kick edge or jumper removal frees it
        if (!watchdog_enable_jumper)
        begin
          next_cur.state     = WD_OFF;
          next_cur.timeout_n = 1'b1;
        end
        else if (kick_edge)
        begin
          next_cur.state     = WD_RUN;
          next_cur.count     = '0;
          next_cur.timeout_n = 1'b1;
        end
      end
      default:
      begin
        next_cur.state     = WD_OFF;
        next_cur.timeout_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cur <= '{state: WD_OFF, kick_prev: 1'b0, kick_seen: 1'b0, count: '0, timeout_n: 1'b1};
    else
      cur <= next_cur;
  end

  assign watchdog_timeout_output_n = cur.timeout_n;

  // ****************************************************************
  // power-fail warning
  // ****************************************************************
  power_fail_filter u_pf
  (
    .clk                         (clk),
    .srst                        (srst),
    .below_threshold             (power_fail_sense_input),
    .power_fail_warning_output_n (power_fail_warning_output_n)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  jumper_off_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !watchdog_enable_jumper |=> watchdog_timeout_output_n)
    else $error("timeout asserted while jumper absent");

  expire_fires_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_RUN && watchdog_enable_jumper && !kick_edge && cur.count == LIMIT)
      |=> !watchdog_timeout_output_n)
    else $error("timeout not asserted at end of interval");

  hold_low_a: assert property (@(posedge clk) disable iff (srst)
    (!watchdog_timeout_output_n && watchdog_enable_jumper && !kick_edge)
      |=> !watchdog_timeout_output_n)
    else $error("timeout released without a kick");

  kick_releases_a: assert property (@(posedge clk) disable iff (srst)
    (!watchdog_timeout_output_n && kick_edge) |=> watchdog_timeout_output_n)
    else $error("kick did not release timeout");

  kick_restarts_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_RUN && watchdog_enable_jumper && kick_edge) |=> cur.count == '0)
    else $error("kick did not restart interval");

  no_early_fire_a: assert property (@(posedge clk) disable iff (srst)
    $fell(watchdog_timeout_output_n) |-> $past(cur.count) == LIMIT)
    else $error("timeout asserted before full interval");

  // ****************************************************************
  // state bookkeeping checks
  // ****************************************************************
  off_clears_count_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_OFF)
      |=> cur.count == '0)
    else $error("count not cleared while disabled");

  enable_starts_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_OFF && watchdog_enable_jumper)
      |=> (cur.state == WD_RUN && cur.count == '0))
    else $error("fitting the jumper did not start the interval");

  jumper_disables_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state != WD_OFF && !watchdog_enable_jumper)
      |=> cur.state == WD_OFF)
    else $error("jumper removal did not disable the watchdog");

  off_ignores_kick_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_OFF && !watchdog_enable_jumper)
      |=> cur.state == WD_OFF)
    else $error("watchdog left the disabled state without the jumper");

  run_counts_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_RUN && watchdog_enable_jumper && !kick_edge && !at_limit(cur.count))
      |=> cur.count == $past(cur.count) + CNT_W'(1))
    else $error("interval count did not advance");

  run_output_high_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state != WD_EXPIRED)
      |-> watchdog_timeout_output_n)
    else $error("timeout low outside the expired state");

  expired_output_low_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_EXPIRED)
      |-> !watchdog_timeout_output_n)
    else $error("timeout high in the expired state");

  kick_reruns_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_EXPIRED && watchdog_enable_jumper && kick_edge)
      |=> (cur.state == WD_RUN && cur.count == '0))
    else $error("kick after timeout did not restart the interval");

  count_bounded_a: assert property (@(posedge clk) disable iff (srst)
    (cur.state == WD_RUN)
      |-> cur.count <= LIMIT)
    else $error("interval count ran past its limit");

  state_onehot_a: assert property (@(posedge clk) disable iff (srst)
    $onehot(cur.state))
    else $error("watchdog state not one-hot");

  timeout_c: cover property (@(posedge clk) disable iff (srst)
    $fell(watchdog_timeout_output_n));
  jumper_drop_c: cover property (@(posedge clk) disable iff (srst)
    cur.state == WD_EXPIRED && !watchdog_enable_jumper);
  recover_c: cover property (@(posedge clk) disable iff (srst)
    $rose(watchdog_timeout_output_n));
  kick_c: cover property (@(posedge clk) disable iff (srst)
    cur.state == WD_RUN && kick_edge);

endmodule : supervisor_watchdog

// ### sim/host_kicker.sv
`timescale 1ns/10ps

// ****************************************************************
// host software model: toggles the kick pin every gap+1 cycles
// ****************************************************************
module host_kicker
(
  input  wire logic       clk,             // system clock
  input  wire logic       srst,            // synchronous reset, active high
  input  wire logic       active,          // periodic kicking on
  input  wire logic [3:0] gap,             // idle cycles between kicks
  input  wire logic       single,          // one extra toggle now
  output logic            kick = 1'b0      // port pin toward the watchdog
);
  logic [3:0] cnt = 4'h0;

  // gap stays below the timeout, so a healthy host never lets it expire
  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt  <= 4'h0;
      kick <= 1'b0;
    end
    else if (single || (active && cnt >= gap))
    begin
      kick <= ~kick;
      cnt  <= 4'h0;
    end
    else if (active)
      cnt <= cnt + 4'h1;
  end
endmodule : host_kicker

// ### sim/testbench.sv
`timescale 1ns/10ps

module testbench;
  import supervisor_pkg::*;
  localparam int unsigned TO = 20;
  logic       clk = 1'b0, srst = 1'b1, jumper = 1'b0, sense = 1'b0;
  logic       active = 1'b0, single = 1'b0, wd_low = 1'b0, pf_low = 1'b0;
  logic [3:0] gap = 4'h1;
  logic       kick, wd_n, pf_n;
  int         n_fail = 0, cmp_count = 0, n;

  always #20 clk = ~clk;

  host_kicker partner (.clk(clk), .srst(srst), .active(active), .gap(gap),
                       .single(single), .kick(kick));
  supervisor_watchdog #(.TIMEOUT_CYCLES(TO)) uut (.clk(clk), .srst(srst),
    .watchdog_kick_input(kick), .watchdog_enable_jumper(jumper),
    .power_fail_sense_input(sense), .watchdog_timeout_output_n(wd_n),
    .power_fail_warning_output_n(pf_n));

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task complete_run;
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task chk(input string name, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %b seen %b", name, exp, seen);
      n_fail++;
    end
  endtask : chk

  // runs n cycles, noting any low on either output
  task run(input int cyc);
    wd_low = 1'b0;
    pf_low = 1'b0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (wd_n !== 1'b1) wd_low = 1'b1;
      if (pf_n !== 1'b1) pf_low = 1'b1;
    end
  endtask : run

  // bounded wait: a wait that runs out ends the run as a failure
  task wait_for(input bit pf, input logic v, input int bound);
    n = 0;
    while ((pf ? pf_n : wd_n) !== v && n < bound)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(pf ? "warning_n" : "timeout_n", pf ? pf_n : wd_n, v);
    if ((pf ? pf_n : wd_n) !== v)
      complete_run();
  endtask : wait_for

  task kick_once;
    @(posedge clk);
    single <= 1'b1;
    @(posedge clk);
    single <= 1'b0;
    #1;
  endtask : kick_once

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(84));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    run(1);
    chk("timeout_n", wd_n, 1'b1);
    chk("warning_n", pf_n, 1'b1);
    // jumper absent: kick never arrives yet no reset follows
    run(3 * TO);
    chk("timeout_n low", wd_low, 1'b0);
    @(posedge clk);
    jumper <= 1'b1;
    active <= 1'b1;
    // random spacing, 0 gives back-to-back toggles, 15 the widest
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      gap <= (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom_range(0, 15));
      // a three-sample sense glitch must be filtered out
      sense <= (i % 7 == 3);
      run(2);
      chk("timeout_n low", wd_low, 1'b0);
      @(posedge clk);
      sense <= 1'b0;
      run(14);
      chk("timeout_n low", wd_low, 1'b0);
      chk("warning_n low", pf_low, 1'b0);
    end
    @(posedge clk);
    active <= 1'b0;
    kick_once();
    run(TO - 4);
    chk("timeout_n early", wd_low, 1'b0);
    wait_for(1'b0, 1'b0, 8);
    run(2 * TO);
    chk("timeout_n held", wd_n, 1'b0);
    kick_once();
    wait_for(1'b0, 1'b1, 3);
    wait_for(1'b0, 1'b0, TO + 4);
    @(posedge clk);
    jumper <= 1'b0;
    wait_for(1'b0, 1'b1, 3);
    @(posedge clk);
    sense <= 1'b1;
    wait_for(1'b1, 1'b0, 7);
    @(posedge clk);
    sense <= 1'b0;
    wait_for(1'b1, 1'b1, 7);
    complete_run();
  end
endmodule : testbench
